// ---- core/bpl_defines.svh ----
`ifndef BPL_DEFINES_SVH
`define BPL_DEFINES_SVH

// ************************************************************
// Clock and timing.
// ************************************************************
`define BPL_CLK_MHZ     200
`define BPL_BIT_US      1000
`define BPL_MIN_US      900
`define BPL_MAX_US      1100
`define BPL_ENTRY_US    100
`define BPL_BIT_CYC     (`BPL_BIT_US * `BPL_CLK_MHZ)
`define BPL_MIN_CYC     (`BPL_MIN_US * `BPL_CLK_MHZ)
`define BPL_MAX_CYC     (`BPL_MAX_US * `BPL_CLK_MHZ)
`define BPL_ENTRY_CYC   (`BPL_ENTRY_US * `BPL_CLK_MHZ)

// ************************************************************
// Word layout and reset values.
// ************************************************************
`define BPL_WORD_W      8
`define BPL_CNT_W       18
`define BPL_PIN_RST     1'h1

`endif

// ---- core/bpl_pkg.sv ----
`include "bpl_defines.svh"

package bpl_pkg;
   typedef logic [`BPL_CNT_W-1:0]  bpl_cnt_t;
   typedef logic [`BPL_WORD_W-1:0] bpl_word_t;
   typedef enum logic [1:0] {MODE_BOOT, MODE_APP, MODE_PROG} bpl_mode_e;
   typedef enum logic [1:0] {TX_IDLE, TX_BIT, TX_TAIL} bpl_tx_e;
endpackage

// ---- core/bpl_buf_if.sv ----
`timescale 1ns/100ps

interface bpl_buf_if;
   import bpl_pkg::*;
   bpl_word_t data;
   logic      valid;
   logic      ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// ---- core/bpl_fifo2.sv ----
`timescale 1ns/100ps

module bpl_fifo2
   import bpl_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_b,
   // Filling and draining sides.
   bpl_buf_if.snk   in_p,
   bpl_buf_if.src   out_p
);

   bpl_word_t head_ff, spare_ff;
   logic [1:0] cnt_ff, nxt_cnt;
   logic       rdy_ff, vld_ff;
   wire        push = in_p.valid & rdy_ff;
   wire        pop  = vld_ff & out_p.ready;

   // ************************************************************
   // Occupancy.
   // ************************************************************
   // The head entry is the output register itself, so data leaves from a flop.
   always_comb begin
      nxt_cnt = cnt_ff;
      if (push && !pop) begin
         nxt_cnt = cnt_ff + 2'h1;
      end else if (pop && !push) begin
         nxt_cnt = cnt_ff - 2'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff   <= 2'h0;
         rdy_ff   <= 1'h0;
         vld_ff   <= 1'h0;
         head_ff  <= '0;
         spare_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
         rdy_ff <= (nxt_cnt != 2'h2);
         vld_ff <= (nxt_cnt != 2'h0);
         if (push && (cnt_ff == 2'h0 || (cnt_ff == 2'h1 && pop))) begin
            head_ff <= in_p.data;
         end else if (pop && cnt_ff == 2'h2) begin
            head_ff <= spare_ff;
         end
         if (push && cnt_ff == 2'h1 && !pop) begin
            spare_ff <= in_p.data;
         end
      end
   end

   assign in_p.ready  = rdy_ff;
   assign out_p.valid = vld_ff;
   assign out_p.data  = head_ff;

   // A full buffer must refuse, or the receiver would overwrite a word.
   chk_full_refuses: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (cnt_ff == 2'h2) |-> !rdy_ff)
      else $error("Full buffer still accepts words.");

endmodule

// ---- core/bpl_link.sv ----
`timescale 1ns/100ps

`include "bpl_defines.svh"

module bpl_link
   import bpl_pkg::*;
#(
   parameter int BIT_CYC   = `BPL_BIT_CYC,
   parameter int MIN_CYC   = `BPL_MIN_CYC,
   parameter int MAX_CYC   = `BPL_MAX_CYC,
   parameter int ENTRY_CYC = `BPL_ENTRY_CYC
)(
   // Clock and reset.
   input  wire logic      sys_clk,
   input  wire logic      rst_b,
   // Shared I/O pin.
   input  wire logic      pin_in,
   output logic           pin_out,
   output logic           pin_oe,
   // Configuration.
   input  wire logic      cfg_freeze,
   output logic           frozen,
   output logic           prog_mode,
   // Received words.
   output bpl_word_t      rx_data,
   output logic           rx_valid,
   input  wire logic      rx_ready,
   output logic           rx_err,
   // Words to send.
   input  wire bpl_word_t tx_data,
   input  wire logic      tx_valid,
   output logic           tx_ready
);

   localparam bpl_cnt_t BIT_C   = bpl_cnt_t'(BIT_CYC);
   localparam bpl_cnt_t HALF_C  = bpl_cnt_t'(BIT_CYC / 2);
   localparam bpl_cnt_t MIN_C   = bpl_cnt_t'(MIN_CYC);
   localparam bpl_cnt_t MAX_C   = bpl_cnt_t'(MAX_CYC);
   localparam bpl_cnt_t HMIN_C  = bpl_cnt_t'(MIN_CYC / 2);
   localparam bpl_cnt_t HMAX_C  = bpl_cnt_t'(MAX_CYC / 2);
   localparam bpl_cnt_t ENTRY_C = bpl_cnt_t'(ENTRY_CYC);

   // True when an interval falls inside an accepted window.
   function automatic logic in_win(bpl_cnt_t v, bpl_cnt_t lo, bpl_cnt_t hi);
      in_win = (v >= lo) && (v <= hi);
   endfunction

   // ************************************************************
   // Pin synchroniser and edge detection.
   // ************************************************************
   logic sync1_ff, sync2_ff, last_ff;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_ff <= `BPL_PIN_RST;
         sync2_ff <= `BPL_PIN_RST;
         last_ff  <= `BPL_PIN_RST;
      end else begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
         last_ff  <= sync2_ff;
      end
   end

   wire edge_seen = sync2_ff ^ last_ff;
   wire rise_seen = sync2_ff & ~last_ff;

   // Time since the last edge; saturates so long idle stays recognisable.
   bpl_cnt_t gap_ff;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_ff <= '1;
      end else if (edge_seen) begin
         gap_ff <= bpl_cnt_t'(1); // An interval of n cycles then reads n at the next edge.
      end else if (gap_ff != '1) begin
         gap_ff <= gap_ff + bpl_cnt_t'(1);
      end
   end

   // ************************************************************
   // Mode control.
   // ************************************************************
   // The freeze strap is caught by a clocked process after reset release.
   bpl_mode_e mode_ff, nxt_mode;
   logic      freeze_ff;
   wire       entry_ok = (mode_ff == MODE_APP) && !freeze_ff && rise_seen && (gap_ff >= ENTRY_C);

   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         MODE_BOOT: nxt_mode = MODE_APP;
         MODE_APP:  if (entry_ok) begin
            nxt_mode = MODE_PROG;
         end
         MODE_PROG: nxt_mode = MODE_PROG;
         default:   nxt_mode = MODE_APP;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_ff   <= MODE_BOOT;
         freeze_ff <= 1'h0;
         prog_mode <= 1'h0;
      end else begin
         mode_ff   <= nxt_mode;
         prog_mode <= (nxt_mode == MODE_PROG);
         if (mode_ff == MODE_BOOT) begin
            freeze_ff <= cfg_freeze;
         end
      end
   end

   assign frozen = freeze_ff;

   // ************************************************************
   // Biphase receiver.
   // ************************************************************
   // Own transmissions echo on the pin, so the receiver is deaf while driving.
   logic      rx_act_ff, half_ff, rx_err_ff;
   bpl_word_t rx_sh_ff;
   logic [3:0] rx_n_ff;
   logic      push_ff;
   bpl_word_t push_data_ff;
   wire       push_rdy;
   wire       listen   = prog_mode && !pin_oe;
   wire       is_full  = in_win(gap_ff, MIN_C, MAX_C);
   wire       is_half  = in_win(gap_ff, HMIN_C, HMAX_C);
   wire       timeout  = rx_act_ff && (gap_ff > MAX_C);
   wire       bit_zero = listen && edge_seen && rx_act_ff && is_full && !half_ff;
   wire       bit_one  = listen && edge_seen && rx_act_ff && is_half && half_ff;
   wire       bit_done = bit_zero || bit_one;
   wire       bad_gap  = listen && edge_seen && rx_act_ff && !is_half && !bit_zero;
   wire       word_end = bit_done && (rx_n_ff == 4'(`BPL_WORD_W - 1));

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_act_ff    <= 1'h0;
         half_ff      <= 1'h0;
         rx_sh_ff     <= '0;
         rx_n_ff      <= 4'h0;
         rx_err_ff    <= 1'h0;
         push_ff      <= 1'h0;
         push_data_ff <= '0;
      end else begin
         rx_err_ff <= (bad_gap || (timeout && rx_n_ff != 4'h0)) && !push_ff;
         if (push_ff && push_rdy) begin
            push_ff <= 1'h0;
         end
         if (!listen || timeout || bad_gap) begin
            rx_act_ff <= listen && edge_seen;
            half_ff   <= 1'h0;
            rx_n_ff   <= 4'h0;
         end else if (edge_seen && !rx_act_ff) begin
            rx_act_ff <= 1'h1; // The first edge only opens the telegram.
         end else if (edge_seen) begin
            half_ff <= is_half && !half_ff;
            if (bit_done) begin
               rx_sh_ff <= {rx_sh_ff[`BPL_WORD_W-2:0], bit_one};
               rx_n_ff  <= word_end ? 4'h0 : rx_n_ff + 4'h1;
            end
            if (word_end) begin
               push_ff      <= 1'h1;
               push_data_ff <= {rx_sh_ff[`BPL_WORD_W-2:0], bit_one};
            end
         end
      end
   end

   assign rx_err = rx_err_ff;

   // A stalled consumer is absorbed by two entries; a word may still drop if
   // the consumer stalls for longer than three words take on the wire.
   bpl_buf_if fill_p ();
   bpl_buf_if drain_p ();
   assign fill_p.data   = push_data_ff;
   assign fill_p.valid  = push_ff;
   assign push_rdy      = fill_p.ready;
   assign rx_data       = drain_p.data;
   assign rx_valid      = drain_p.valid;
   assign drain_p.ready = rx_ready;

   bpl_fifo2 u_rx_buf (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .in_p    (fill_p),
      .out_p   (drain_p)
   );

   // ************************************************************
   // Biphase transmitter.
   // ************************************************************
   // Acknowledges and write results leave through this path as ordinary words.
   bpl_tx_e   tx_st_ff, nxt_tx_st;
   bpl_cnt_t  tx_cnt_ff;
   bpl_word_t tx_sh_ff;
   logic [3:0] tx_n_ff;
   wire       tx_go    = (tx_st_ff == TX_IDLE) && tx_valid && tx_ready;
   wire       cell_mid = (tx_st_ff == TX_BIT) && (tx_cnt_ff == HALF_C - bpl_cnt_t'(1));
   wire       cell_end = (tx_st_ff == TX_BIT) && (tx_cnt_ff == BIT_C - bpl_cnt_t'(1));
   wire       last_bit = tx_n_ff == 4'(`BPL_WORD_W - 1);
   wire       tail_end = (tx_st_ff == TX_TAIL) && (tx_cnt_ff == HALF_C - bpl_cnt_t'(1));
   wire       flip     = tx_go || cell_end || (cell_mid && tx_sh_ff[`BPL_WORD_W-1]);

   always_comb begin
      nxt_tx_st = tx_st_ff;
      case (tx_st_ff)
         TX_IDLE: if (tx_go) begin
            nxt_tx_st = TX_BIT;
         end
         TX_BIT:  if (cell_end && last_bit) begin
            nxt_tx_st = TX_TAIL;
         end
         TX_TAIL: if (tail_end) begin
            nxt_tx_st = TX_IDLE;
         end
         default: nxt_tx_st = TX_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_st_ff  <= TX_IDLE;
         tx_cnt_ff <= '0;
         tx_sh_ff  <= '0;
         tx_n_ff   <= 4'h0;
         pin_out   <= `BPL_PIN_RST;
         pin_oe    <= 1'h0;
         tx_ready  <= 1'h0;
      end else begin
         tx_st_ff  <= nxt_tx_st;
         tx_cnt_ff <= (tx_go || cell_end || tail_end) ? '0 : tx_cnt_ff + bpl_cnt_t'(1);
         pin_oe    <= (nxt_tx_st != TX_IDLE);
         tx_ready  <= (nxt_tx_st == TX_IDLE) && prog_mode && !rx_act_ff && !tx_go;
         // The start edge leaves from the released level, whatever was driven last.
         if (tx_go) begin
            pin_out <= ~`BPL_PIN_RST;
         end else if (flip) begin
            pin_out <= ~pin_out;
         end
         if (tx_go) begin
            tx_sh_ff <= tx_data;
            tx_n_ff  <= 4'h0;
         end else if (cell_end) begin
            tx_sh_ff <= {tx_sh_ff[`BPL_WORD_W-2:0], 1'h0};
            tx_n_ff  <= tx_n_ff + 4'h1;
         end
      end
   end

   // ************************************************************
   // Checks.
   // ************************************************************
   chk_prog_entry_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(prog_mode) |-> $past(rise_seen) && !freeze_ff)
      else $error("Programming mode entered without an entry pulse.");

   chk_frozen_stays_app: assert property (@(posedge sys_clk) disable iff (!rst_b)
      freeze_ff && (mode_ff != MODE_BOOT) |-> !prog_mode)
      else $error("Frozen device entered programming mode.");

   chk_drive_in_prog: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pin_oe |-> prog_mode)
      else $error("Pin driven outside programming mode.");

   chk_zero_no_mid: assert property (@(posedge sys_clk) disable iff (!rst_b)
      cell_mid && !tx_sh_ff[`BPL_WORD_W-1] |=> $stable(pin_out))
      else $error("Zero cell toggled in its middle.");

   chk_one_mid_flip: assert property (@(posedge sys_clk) disable iff (!rst_b)
      cell_mid && tx_sh_ff[`BPL_WORD_W-1] |=> (pin_out != $past(pin_out)))
      else $error("One cell missed its middle toggle.");

   chk_cell_end_flip: assert property (@(posedge sys_clk) disable iff (!rst_b)
      cell_end |=> (pin_out != $past(pin_out)) && pin_oe)
      else $error("Cell end without a toggle.");

   chk_cell_length: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (tx_st_ff == TX_BIT) |-> (tx_cnt_ff < BIT_C))
      else $error("Bit cell longer than nominal.");

   chk_word_complete: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(push_ff) |-> $past(rx_n_ff) == 4'(`BPL_WORD_W - 1))
      else $error("Word pushed before all bits arrived.");

   chk_ack_only_prog: assert property (@(posedge sys_clk) disable iff (!rst_b)
      tx_ready |-> prog_mode && (tx_st_ff == TX_IDLE))
      else $error("Reply accepted outside programming mode.");

endmodule

// ---- dv/bpl_prog_model.sv ----
`timescale 1ns/100ps

// ****************************************
// Programmer model on the shared pin.
// ****************************************
module bpl_prog_model
   import bpl_pkg::*;
#(
   parameter int BIT = 40
)(
   // Clock.
   input  wire logic sys_clk,
   // Shared pin.
   input  wire logic pin,
   output logic      drv_en,
   output logic      drv_val
);
   bpl_word_t rxq[$];
   bpl_word_t sh;
   int        gap;
   int        bits;
   int        bad;
   logic      half;
   logic      last;
   logic      open;

   initial begin
      drv_en  = 1'h0;
      drv_val = 1'h1;
      gap     = 0;
      bits    = 0;
      bad     = 0;
      half    = 1'h0;
      last    = 1'h1;
      open    = 1'h0;
   end

   // One call is one edge on the line.
   task automatic flip(input int n);
      repeat (n) @(negedge sys_clk);
      drv_val = ~drv_val;
   endtask

   // A long low phase ended by a rise asks for programming mode.
   task automatic entry(input int n);
      @(negedge sys_clk);
      drv_val = 1'h0;
      drv_en  = 1'h1;
      repeat (n) @(negedge sys_clk);
      drv_en = 1'h0;
   endtask

   // Sends one word MSB first; the long rest lets the receiver go idle.
   task automatic send(input bpl_word_t w, input int cyc);
      @(negedge sys_clk);
      drv_val = 1'h1;
      drv_en  = 1'h1;
      flip(1);
      for (int i = 7; i >= 0; i--) begin
         if (w[i]) begin
            flip(cyc / 2);
            flip(cyc - cyc / 2);
         end else begin
            flip(cyc);
         end
      end
      repeat (cyc / 2) @(negedge sys_clk);
      drv_en = 1'h0;
      repeat (3 * cyc / 2) @(negedge sys_clk);
   endtask

   task automatic take(input logic b);
      if (bits == 7) begin
         rxq.push_back({sh[6:0], b});
         bits <= 0;
      end else begin
         bits <= bits + 1;
      end
      sh <= {sh[6:0], b};
   endtask

   // Decodes the device's replies; only exact cell lengths are taken.
   always @(posedge sys_clk) begin
      last <= pin;
      gap  <= gap + 1;
      if (drv_en || gap > 2 * BIT) begin
         open <= 1'h0;
      end
      if (!drv_en && pin !== last) begin
         gap  <= 1;
         open <= 1'h1;
         if (open && gap == BIT && !half) begin
            take(1'h0);
         end else if (open && gap == BIT / 2 && half) begin
            take(1'h1);
            half <= 1'h0;
         end else if (open && gap == BIT / 2) begin
            half <= 1'h1;
         end else begin
            bad  <= bad + ((open && bits != 0) ? 1 : 0);
            bits <= 0;
            half <= 1'h0;
         end
      end
   end
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/100ps

// ****************************************
// Link bench with a programmer model.
// ****************************************
module testbench
   import bpl_pkg::*;
;
   localparam int BIT = 40;
   logic      sys_clk, rst_b, cfg_freeze, rx_ready, tx_valid, pin;
   logic      pin_out, pin_oe, frozen, prog_mode, rx_valid, rx_err;
   logic      tx_ready, drv_en, drv_val;
   bpl_word_t rx_data, tx_data, w, got;
   bpl_word_t exp_q[$];
   int        err_count, num_checks, seed, n_err, k;

   // The line has a pull-up, so a released pin reads high.
   assign pin = pin_oe ? pin_out : (drv_en ? drv_val : 1'h1);

   bpl_link #(.BIT_CYC(BIT), .MIN_CYC(36), .MAX_CYC(44), .ENTRY_CYC(10)) dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .pin_in(pin), .pin_out(pin_out),
      .pin_oe(pin_oe), .cfg_freeze(cfg_freeze), .frozen(frozen),
      .prog_mode(prog_mode), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_err(rx_err), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready));

   // The model's default cell length already equals BIT.
   bpl_prog_model pm (
      .sys_clk(sys_clk), .pin(pin), .drv_en(drv_en), .drv_val(drv_val));

   initial begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Error pulses last one cycle, so they are counted as they pass.
   always @(posedge sys_clk) begin
      if (rx_err === 1'h1) begin
         n_err <= n_err + 1;
      end
   end

   task automatic check(input string nm, input logic [17:0] seen, input logic [17:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("Checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic do_reset(input logic frz);
      @(negedge sys_clk);
      rst_b      = 1'h0;
      cfg_freeze = frz;
      repeat (8) @(negedge sys_clk);
      rst_b = 1'h1;
      repeat (3) @(negedge sys_clk);
   endtask

   task automatic get_word(output bpl_word_t d);
      int n;
      n = 0;
      while (rx_valid !== 1'h1 && n < 400) begin
         @(negedge sys_clk);
         n++;
      end
      check("rx arrives", rx_valid, 1);
      // A random stall shows that the word stands until it is taken.
      repeat ($unsigned($random(seed)) % 4) @(negedge sys_clk);
      d        = rx_data;
      rx_ready = 1'h1;
      @(negedge sys_clk);
      rx_ready = 1'h0;
      @(negedge sys_clk);
   endtask

   // The request stays up until an edge that sees ready high.
   task automatic put_word(input bpl_word_t d);
      int n;
      n        = 0;
      tx_data  = d;
      tx_valid = 1'h1;
      while (tx_ready !== 1'h1 && n < 2000) begin
         @(negedge sys_clk);
         n++;
      end
      check("tx taken", tx_ready, 1);
      @(negedge sys_clk);
      tx_valid = 1'h0;
      @(negedge sys_clk);
   endtask

   initial begin
      seed       = 11;
      err_count  = 0;
      num_checks = 0;
      n_err      = 0;
      rst_b      = 1'h0;
      cfg_freeze = 1'h1;
      rx_ready   = 1'h0;
      tx_valid   = 1'h0;
      tx_data    = 8'h00;
      // A frozen device ignores entry and telegrams.
      do_reset(1'h1);
      check("frozen", frozen, 1);
      pm.entry(12);
      pm.send(8'h5A, BIT);
      check("frozen mode", prog_mode, 0);
      check("no reply", rx_valid, 0);
      do_reset(1'h0);
      check("unfrozen", frozen, 0);
      check("boot mode", prog_mode, 0);
      pm.entry(5);
      tx_valid = 1'h1;
      repeat (20) @(negedge sys_clk);
      check("short pulse", prog_mode, 0);
      check("tx refused", tx_ready, 0);
      tx_valid = 1'h0;
      pm.entry(12);
      repeat (8) @(negedge sys_clk);
      check("entry", prog_mode, 1);
      // Receive at nominal and at both edges of the accepted cell length.
      for (int i = 0; i < 6; i++) begin
         w = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
         pm.send(w, (i % 3 == 0) ? BIT : (i % 3 == 1) ? 36 : 44);
         get_word(got);
         check("rx word", got, w);
      end
      // Two words wait while the consumer stalls.
      pm.send(8'h3C, BIT);
      pm.send(8'hC3, BIT);
      check("rx held", rx_valid, 1);
      get_word(got);
      check("rx first", got, 8'h3C);
      get_word(got);
      check("rx second", got, 8'hC3);
      check("rx clean", n_err, 0);
      n_err = 0;
      pm.send(8'h81, 30);
      check("short cell", n_err > 0, 1);
      // Replies, the last ones back to back.
      for (int i = 0; i < 4; i++) begin
         w = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
         exp_q.push_back(w);
         put_word(w);
      end
      k = 0;
      while (pm.rxq.size() < 4 && k < 1000) begin
         @(negedge sys_clk);
         k++;
      end
      foreach (exp_q[j]) begin
         check("tx word", (pm.rxq.size() > j) ? pm.rxq[j] : ~exp_q[j], exp_q[j]);
      end
      check("tx cells", pm.bad, 0);
      end_sim();
   end

   // The sequence needs about 5500 cycles; roughly eleven times that means a hang.
   initial begin
      repeat (60000) @(posedge sys_clk);
      err_count++;
      end_sim();
   end
endmodule
